// ---- design/cpm_pkg.sv ----
// Shared constants for the processor programming-model register set.
package cpm_pkg;

    // ------------------------------------------------------------
    // Register indices on the register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] IDX_GPR_LAST = 5'h07;
    localparam logic [4:0] IDX_INSTR_PTR = 5'h08;
    localparam logic [4:0] IDX_ISP = 5'h09;
    localparam logic [4:0] IDX_USP = 5'h0a;
    localparam logic [4:0] IDX_FRAME = 5'h0b;
    localparam logic [4:0] IDX_STATIC = 5'h0c;
    localparam logic [4:0] IDX_ITB = 5'h0d;
    localparam logic [4:0] IDX_MODP = 5'h0e;
    localparam logic [4:0] IDX_STATUS = 5'h0f;
    localparam logic [4:0] IDX_CONFIG = 5'h10;

    // ------------------------------------------------------------
    // Operand sizes and pointer masks
    // ------------------------------------------------------------
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_DWORD = 2'h2;
    localparam logic [31:0] PTR_MASK = 32'h00ff_ffff;
    localparam logic [31:0] MODP_MASK = 32'h0000_ffff;
    localparam logic [2:0] FRAME_LEN = 3'h4;

    // ------------------------------------------------------------
    // Status word layout and reset values
    // ------------------------------------------------------------
    // RULE24 fixed status layout
    localparam int ST_C = 0;
    localparam int ST_T = 1;
    localparam int ST_L = 2;
    localparam int ST_F = 5;
    localparam int ST_Z = 6;
    localparam int ST_N = 7;
    localparam int ST_U = 8;
    localparam int ST_S = 9;
    localparam int ST_P = 10;
    localparam int ST_I = 11;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_USED = 16'h0fe7;

    // ------------------------------------------------------------
    // Configuration layout and reset value
    // ------------------------------------------------------------
    localparam int CF_I = 0;
    localparam int CF_F = 1;
    localparam int CF_M = 2;
    localparam int CF_C = 3;
    localparam logic [3:0] CONFIG_RESET = 4'h0;

endpackage

// ---- design/cpm_cmp_flags.sv ----
// Compare flag evaluation for integer and floating compares.
`timescale 1ns/1ps
`default_nettype none

module cpm_cmp_flags
    import cpm_pkg::*;
#(
    parameter int DW = 32
) (
    input wire logic [DW-1:0] first_i,
    input wire logic [DW-1:0] second_i,
    input wire logic is_float_i,
    output logic low_o,
    output logic zero_o,
    output logic neg_o
);

    // ------------------------------------------------------------
    // Flag logic
    // ------------------------------------------------------------
    always_comb begin
        // RULE9 unsigned low flag
        low_o = is_float_i ? 1'b0 : (second_i < first_i);
        // RULE10 equality flag
        zero_o = (second_i == first_i);
        // RULE11 signed less flag
        neg_o = ($signed(second_i) < $signed(first_i));
    end

endmodule
`default_nettype wire

// ---- design/cpm_stack.sv ----
// Interrupt and user stack pointers with push and pop adjustment.
`timescale 1ns/1ps
`default_nettype none

module cpm_stack
    import cpm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic sel_user_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [2:0] len_i,
    input wire logic wr_isp_i,
    input wire logic wr_usp_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] isp_o,
    output logic [31:0] usp_o,
    output logic [31:0] active_o
);

    logic [31:0] next_active;

    // ------------------------------------------------------------
    // Pointer update
    // ------------------------------------------------------------
    always_comb begin
        // RULE3 stack select
        active_o = sel_user_i ? usp_o : isp_o;
        // RULE4 pre-decrement, post-increment
        next_active = active_o;
        if (push_i) begin
            next_active = active_o - {29'h0, len_i};
        end else if (pop_i) begin
            next_active = active_o + {29'h0, len_i};
        end
        next_active = next_active & PTR_MASK;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            isp_o <= 32'h0;
            usp_o <= 32'h0;
        end else if (ce_i) begin
            // RULE2 upper byte zero
            if (wr_isp_i) begin
                isp_o <= wdata_i & PTR_MASK;
            end else if (!sel_user_i && (push_i || pop_i)) begin
                isp_o <= next_active;
            end
            if (wr_usp_i) begin
                usp_o <= wdata_i & PTR_MASK;
            end else if (sel_user_i && (push_i || pop_i)) begin
                usp_o <= next_active;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_push_dec;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        ce_i && push_i && !wr_isp_i && !wr_usp_i |=>
            active_o == (($past(active_o) - {29'h0, $past(len_i)})
                         & PTR_MASK);
    endproperty
    // RULE4 push moves pointer
    a_push_dec: assert property (p_push_dec) else $error("push wrong"); // RULE4

endmodule
`default_nettype wire

// ---- design/cpm_regs.sv ----
// Programming-model register set: general, dedicated, status, config.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Eight 32-bit general registers; byte and word writes keep upper bits.
// RULE2: Instruction, stack, frame, static and table pointers keep top byte zero.
// RULE3: Status S bit 0 selects interrupt stack, 1 selects user stack.
// RULE4: Push pre-decrements, pop post-increments active stack by length.
// RULE5: Module pointer is 16 bits wide.
// RULE6: Status low byte open to all; high byte only in supervisor.
// RULE7: Carry set on add or subtract carry or borrow, else cleared.
// RULE8: Trace bit set causes a trace trap after each instruction.
// RULE9: Integer compare sets low flag on unsigned less; float clears it.
// RULE10: Compare sets zero flag when operands are equal.
// RULE11: Compare sets negative flag on signed less.
// RULE12: General flag written by instructions; arithmetic marks overflow.
// RULE13: User mode refuses privileged ops and protected writes.
// RULE14: Interrupt or trap entry clears stack select.
// RULE15: Trace pending bit allows at most one trace trap per instruction.
// RULE16: Interrupt enable gates maskable requests; NMI always taken.
// RULE17: Four-bit configuration loaded only by configuration instruction.
// RULE18: Privilege output high in user mode, low in supervisor.
// RULE19: Instruction pointer holds first byte address of current instruction.
// RULE20: Frame pointer loaded on procedure entry, restored on exit.
// RULE21: Configuration interrupt bit selects vectored maskable interrupts.
// RULE22: Missing coprocessor bits make their instructions trap undefined.
// RULE23: Masked pointer writes drop top byte; reads return zero there.
// RULE24: Status and configuration bit positions fixed in the package.

module cpm_regs
    import cpm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [1:0] reg_size_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_denied_o,
    input wire logic instr_start_i,
    input wire logic [31:0] instr_addr_i,
    input wire logic instr_done_i,
    output logic trace_trap_o,
    input wire logic cmp_i,
    input wire logic cmp_float_i,
    input wire logic [31:0] cmp_first_i,
    input wire logic [31:0] cmp_second_i,
    input wire logic arith_i,
    input wire logic carry_i,
    input wire logic overflow_i,
    input wire logic flag_wr_i,
    input wire logic flag_val_i,
    output logic carry_o,
    input wire logic stk_push_i,
    input wire logic stk_pop_i,
    input wire logic [2:0] stk_len_i,
    output logic [31:0] sp_o,
    input wire logic frame_enter_i,
    input wire logic frame_exit_i,
    input wire logic [31:0] frame_restore_i,
    input wire logic exc_entry_i,
    input wire logic priv_op_i,
    output logic priv_trap_o,
    input wire logic int_n_i,
    input wire logic nmi_n_i,
    output logic irq_take_o,
    output logic nmi_take_o,
    output logic irq_vectored_o,
    input wire logic float_op_i,
    input wire logic mmu_op_i,
    input wire logic cust_op_i,
    output logic undef_trap_o,
    input wire logic load_configuration_instruction_i,
    input wire logic [3:0] cfg_data_i,
    output logic user_mode_o
);

    logic [31:0] gpr [0:7];
    logic [31:0] instr_ptr;
    logic [31:0] frame_pointer;
    logic [31:0] static_base;
    logic [31:0] itb;
    logic [15:0] module_pointer;
    logic [15:0] status;
    logic [3:0] sys_config;
    logic [31:0] isp;
    logic [31:0] usp;
    logic [31:0] active_sp;
    logic [1:0] int_sync;
    logic [1:0] nmi_sync;
    logic nmi_seen;
    logic wr_ok;
    logic user_mode;
    logic cmp_low;
    logic cmp_zero;
    logic cmp_neg;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_protected(input logic [4:0] idx);
        is_protected = (idx == IDX_INSTR_PTR) || (idx == IDX_ISP) ||
                       (idx == IDX_ITB) || (idx == IDX_CONFIG);
    endfunction

    function automatic logic [31:0] sized(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [1:0] size);
        case (size)
            SIZE_BYTE: sized = {old_v[31:8], new_v[7:0]};
            SIZE_WORD: sized = {old_v[31:16], new_v[15:0]};
            default: sized = new_v;
        endcase
    endfunction

    function automatic logic [31:0] read_sized(input logic [31:0] v,
                                               input logic [1:0] size);
        case (size)
            SIZE_BYTE: read_sized = {24'h0, v[7:0]};
            SIZE_WORD: read_sized = {16'h0, v[15:0]};
            default: read_sized = v;
        endcase
    endfunction

    assign user_mode = status[ST_U];
    // RULE13 protected writes refused
    assign wr_ok = reg_we_i && !(user_mode && is_protected(reg_addr_i));

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    cpm_cmp_flags #(
        .DW(32)
    ) u_cmp (
        .first_i(cmp_first_i),
        .second_i(cmp_second_i),
        .is_float_i(cmp_float_i),
        .low_o(cmp_low),
        .zero_o(cmp_zero),
        .neg_o(cmp_neg)
    );

    cpm_stack u_stack (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .sel_user_i(status[ST_S]),
        .push_i(stk_push_i || frame_enter_i),
        .pop_i(stk_pop_i || frame_exit_i),
        .len_i(frame_enter_i || frame_exit_i ? FRAME_LEN : stk_len_i),
        .wr_isp_i(wr_ok && reg_addr_i == IDX_ISP),
        .wr_usp_i(wr_ok && reg_addr_i == IDX_USP),
        .wdata_i(reg_wdata_i),
        .isp_o(isp),
        .usp_o(usp),
        .active_o(active_sp)
    );

    // ------------------------------------------------------------
    // General registers
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < 8; g++) begin : g_gpr
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    gpr[g] <= 32'h0;
                end else if (ce_i && wr_ok && reg_addr_i == 5'(g)) begin
                    // RULE1 sized write keeps upper part
                    gpr[g] <= sized(gpr[g], reg_wdata_i, reg_size_i);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Dedicated pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            instr_ptr <= 32'h0;
            static_base <= 32'h0;
            itb <= 32'h0;
            module_pointer <= 16'h0;
        end else if (ce_i) begin
            // RULE19 address of current instruction
            if (instr_start_i) begin
                instr_ptr <= instr_addr_i & PTR_MASK;
            end else if (wr_ok && reg_addr_i == IDX_INSTR_PTR) begin
                instr_ptr <= reg_wdata_i & PTR_MASK;
            end
            // RULE23 upper byte discarded
            if (wr_ok && reg_addr_i == IDX_STATIC) begin
                static_base <= reg_wdata_i & PTR_MASK;
            end
            if (wr_ok && reg_addr_i == IDX_ITB) begin
                itb <= reg_wdata_i & PTR_MASK;
            end
            // RULE5 sixteen-bit module pointer
            if (wr_ok && reg_addr_i == IDX_MODP) begin
                module_pointer <= reg_wdata_i[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_pointer <= 32'h0;
        end else if (ce_i) begin
            // RULE20 frame entry and exit
            if (frame_enter_i) begin
                frame_pointer <= (active_sp - 32'h4) & PTR_MASK;
            end else if (frame_exit_i) begin
                frame_pointer <= frame_restore_i & PTR_MASK;
            end else if (wr_ok && reg_addr_i == IDX_FRAME) begin
                frame_pointer <= reg_wdata_i & PTR_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status <= STATUS_RESET;
        end else if (ce_i) begin
            // RULE6 high byte supervisor only
            if (wr_ok && reg_addr_i == IDX_STATUS) begin
                status[7:0] <= reg_wdata_i[7:0] & STATUS_USED[7:0];
                if (!user_mode) begin
                    status[15:8] <= reg_wdata_i[15:8] & STATUS_USED[15:8];
                end
            end
            // RULE7 carry from arithmetic
            if (arith_i) begin
                status[ST_C] <= carry_i;
            end
            // RULE12 general flag
            if (arith_i) begin
                status[ST_F] <= overflow_i;
            end else if (flag_wr_i) begin
                status[ST_F] <= flag_val_i;
            end
            // RULE9 RULE10 RULE11 compare flags
            if (cmp_i) begin
                status[ST_L] <= cmp_low;
                status[ST_Z] <= cmp_zero;
                status[ST_N] <= cmp_neg;
            end
            // RULE15 trace pending bit
            if (instr_start_i && status[ST_T]) begin
                status[ST_P] <= 1'b1;
            end else if (instr_done_i) begin
                status[ST_P] <= 1'b0;
            end
            // RULE14 entry selects interrupt stack
            if (exc_entry_i) begin
                status[ST_S] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sys_config <= CONFIG_RESET;
        end else if (ce_i && load_configuration_instruction_i && !user_mode) begin
            // RULE17 loaded by configuration instruction only
            sys_config <= cfg_data_i;
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= 32'h0;
            reg_denied_o <= 1'b0;
        end else if (ce_i) begin
            reg_denied_o <= reg_we_i && !wr_ok;
            if (reg_re_i) begin
                case (reg_addr_i)
                    IDX_INSTR_PTR: reg_rdata_o <= instr_ptr;
                    IDX_ISP: reg_rdata_o <= isp;
                    IDX_USP: reg_rdata_o <= usp;
                    IDX_FRAME: reg_rdata_o <= frame_pointer;
                    IDX_STATIC: reg_rdata_o <= static_base;
                    IDX_ITB: reg_rdata_o <= itb;
                    IDX_MODP: reg_rdata_o <= {16'h0, module_pointer};
                    IDX_STATUS: reg_rdata_o <= {16'h0, status};
                    IDX_CONFIG: reg_rdata_o <= {28'h0, sys_config};
                    default: begin
                        if (reg_addr_i <= IDX_GPR_LAST) begin
                            reg_rdata_o <= read_sized(gpr[reg_addr_i[2:0]],
                                                      reg_size_i);
                        end else begin
                            reg_rdata_o <= 32'h0;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pins, traps and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            int_sync <= 2'h3;
            nmi_sync <= 2'h3;
            nmi_seen <= 1'b0;
            irq_take_o <= 1'b0;
            nmi_take_o <= 1'b0;
            irq_vectored_o <= 1'b0;
        end else if (ce_i) begin
            int_sync <= {int_sync[0], int_n_i};
            nmi_sync <= {nmi_sync[0], nmi_n_i};
            nmi_seen <= !nmi_sync[1];
            // RULE16 maskable gated by enable
            irq_take_o <= !int_sync[1] && status[ST_I];
            nmi_take_o <= !nmi_sync[1] && !nmi_seen;
            // RULE21 vectored mode select
            irq_vectored_o <= sys_config[CF_I];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trace_trap_o <= 1'b0;
            priv_trap_o <= 1'b0;
            undef_trap_o <= 1'b0;
            carry_o <= 1'b0;
            sp_o <= 32'h0;
        end else if (ce_i) begin
            // RULE8 trace trap at instruction end
            trace_trap_o <= instr_done_i && status[ST_P];
            // RULE13 privileged operation refused
            priv_trap_o <= priv_op_i && user_mode;
            // RULE22 absent coprocessor traps
            undef_trap_o <= (float_op_i && !sys_config[CF_F]) ||
                            (mmu_op_i && !sys_config[CF_M]) ||
                            (cust_op_i && !sys_config[CF_C]);
            carry_o <= arith_i ? carry_i : status[ST_C];
            sp_o <= active_sp;
        end
    end

    // RULE18 privilege output
    assign user_mode_o = status[ST_U];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    property p_gpr_upper;
        ce_i && wr_ok && reg_addr_i == 5'h0 && reg_size_i == SIZE_BYTE
        |=> gpr[0][31:8] == $past(gpr[0][31:8]);
    endproperty
    a_gpr_upper: assert property (p_gpr_upper) else $error("gpr"); // RULE1

    property p_ptr_top;
        instr_ptr[31:24] == 8'h0 && frame_pointer[31:24] == 8'h0 &&
        static_base[31:24] == 8'h0 && itb[31:24] == 8'h0;
    endproperty
    a_ptr_top: assert property (p_ptr_top) else $error("top byte"); // RULE2

    property p_high_byte;
        ce_i && user_mode && !exc_entry_i && !instr_start_i &&
        !instr_done_i |=> status[15:8] == $past(status[15:8]);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("hi"); // RULE6

    property p_carry;
        ce_i && arith_i |=> status[ST_C] == $past(carry_i) ##1 1'b1;
    endproperty
    a_carry: assert property (p_carry) else $error("carry"); // RULE7

    property p_trace;
        ce_i && instr_done_i && status[ST_P] |=> trace_trap_o;
    endproperty
    a_trace: assert property (p_trace) else $error("trace"); // RULE8

    property p_zero;
        ce_i && cmp_i |=> status[ST_Z] == ($past(cmp_first_i) ==
                                           $past(cmp_second_i));
    endproperty
    a_zero: assert property (p_zero) else $error("zero"); // RULE10

    property p_exc_stack;
        ce_i && exc_entry_i |=> !status[ST_S];
    endproperty
    a_exc_stack: assert property (p_exc_stack) else $error("s"); // RULE14

    property p_irq_mask;
        irq_take_o |-> $past(status[ST_I]);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq"); // RULE16

    property p_config;
        !$stable(sys_config) |-> $past(load_configuration_instruction_i) && $past(ce_i);
    endproperty
    a_config: assert property (p_config) else $error("config"); // RULE17

    c_trace: cover property (ce_i && instr_done_i ##1 trace_trap_o);
    c_denied: cover property (reg_denied_o);
    c_push: cover property (ce_i && stk_push_i && status[ST_S]);

endmodule
`default_nettype wire

// ---- dv/cpm_tb.sv ----
// Self-checking bench for the programming-model register set.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cpm_pkg::*;
    logic clk_sys_i, rstn_i, ce_i, reg_we_i, reg_re_i, instr_start_i;
    logic instr_done_i, cmp_i, cmp_float_i, arith_i, carry_i, overflow_i;
    logic flag_wr_i, flag_val_i, stk_push_i, stk_pop_i, frame_enter_i;
    logic frame_exit_i, exc_entry_i, priv_op_i, int_n_i, nmi_n_i;
    logic float_op_i, mmu_op_i, cust_op_i, load_configuration_instruction_i;
    logic [4:0] reg_addr_i;
    logic [1:0] reg_size_i;
    logic [2:0] stk_len_i;
    logic [3:0] cfg_data_i;
    logic [12:0] ev;
    logic [31:0] reg_wdata_i, instr_addr_i, cmp_first_i, cmp_second_i;
    logic [31:0] frame_restore_i, reg_rdata_o, sp_o, rdata, v, a, b;
    logic reg_denied_o, trace_trap_o, carry_o, priv_trap_o, irq_take_o;
    logic nmi_take_o, irq_vectored_o, undef_trap_o, user_mode_o;
    int n_mismatch = 0;
    int checks = 0;
    int seed;
    int ops[3] = '{8, 11, 12};
    assign {cust_op_i, mmu_op_i, frame_enter_i, priv_op_i, float_op_i,
            load_configuration_instruction_i, instr_done_i, instr_start_i, arith_i, cmp_i,
            exc_entry_i, stk_pop_i, stk_push_i} = ev;
    cpm_regs cpm_regs_inst (.*);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic acc(input logic w, input logic [4:0] ad,
                       input logic [31:0] d, input logic [1:0] sz);
        @(posedge clk_sys_i);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_size_i <= sz;
        {reg_we_i, reg_re_i} <= {w, !w};
        @(posedge clk_sys_i);
        {reg_we_i, reg_re_i} <= 2'h0;
        #1;
        rdata = reg_rdata_o;
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        ev <= 13'h1 << k;
        @(posedge clk_sys_i);
        ev <= '0;
        #1;
    endtask
    function automatic logic [31:0] cmp_exp(input logic [31:0] f,
        input logic [31:0] s, input logic fl);
        cmp_exp = '0;
        cmp_exp[ST_L] = !fl && (s < f);
        cmp_exp[ST_Z] = (s == f);
        cmp_exp[ST_N] = $signed(s) < $signed(f);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 47609;
        rstn_i = 1'b0;
        ev = '0;
        {reg_we_i, reg_re_i, cmp_float_i, carry_i, overflow_i} = '0;
        {flag_wr_i, flag_val_i, frame_exit_i} = '0;
        {int_n_i, nmi_n_i, ce_i} = 3'h7;
        {reg_addr_i, reg_size_i, stk_len_i, cfg_data_i} = '0;
        {reg_wdata_i, instr_addr_i, cmp_first_i, cmp_second_i} = '0;
        frame_restore_i = '0;
        repeat (5) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        acc(1'b0, IDX_STATUS, '0, SIZE_DWORD);
        chk(rdata, {16'h0, STATUS_RESET});
        v = $random(seed);
        acc(1'b1, 5'h03, v, SIZE_DWORD);
        acc(1'b1, 5'h03, 32'hffff_ff5a, SIZE_BYTE);
        acc(1'b0, 5'h03, '0, SIZE_DWORD);
        chk(rdata, {v[31:8], 8'h5a});
        acc(1'b1, 5'h03, 32'hffff_a5c3, SIZE_WORD);
        acc(1'b0, 5'h03, '0, SIZE_DWORD);
        chk(rdata, {v[31:16], 16'ha5c3});
        for (int i = 8; i < 15; i++) begin
            v = $random(seed);
            acc(1'b1, i[4:0], v, SIZE_DWORD);
            acc(1'b0, i[4:0], '0, SIZE_DWORD);
            chk(rdata, v & ((i == 14) ? MODP_MASK : PTR_MASK));
        end
        acc(1'b1, IDX_ISP, 32'h1000, SIZE_DWORD);
        acc(1'b1, IDX_USP, 32'h2000, SIZE_DWORD);
        stk_len_i <= 3'h4;
        pulse(0);
        pulse(10);
        stk_len_i <= 3'h2;
        pulse(1);
        tick(1);
        chk(sp_o, 32'h0000_0ffa);
        acc(1'b0, IDX_FRAME, '0, SIZE_DWORD);
        chk(rdata, 32'h0000_0ff8);
        acc(1'b1, IDX_STATUS, 32'h0000_0200, SIZE_DWORD);
        tick(1);
        chk(sp_o, 32'h0000_2000);
        pulse(2);
        tick(1);
        chk(sp_o, 32'h0000_0ffa);
        ce_i <= 1'b0;
        pulse(0);
        ce_i <= 1'b1;
        tick(1);
        chk(sp_o, 32'h0000_0ffa);
        frame_restore_i <= 32'hff00_0104;
        frame_exit_i <= 1'b1;
        tick(1);
        frame_exit_i <= 1'b0;
        acc(1'b0, IDX_FRAME, '0, SIZE_DWORD);
        chk(rdata, 32'h0000_0104);
        for (int k = 0; k < 24; k++) begin
            a = $random(seed);
            b = (k < 2) ? a : $random(seed);
            cmp_first_i <= a;
            cmp_second_i <= b;
            cmp_float_i <= k[0];
            pulse(3);
            acc(1'b0, IDX_STATUS, '0, SIZE_DWORD);
            chk(rdata & 32'h0000_00c4, cmp_exp(a, b, k[0]));
        end
        for (int k = 0; k < 4; k++) begin
            {overflow_i, carry_i} <= k[1:0];
            pulse(4);
            chk({31'h0, carry_o}, {31'h0, k[0]});
            acc(1'b0, IDX_STATUS, '0, SIZE_DWORD);
            chk({31'h0, rdata[ST_F]}, {31'h0, k[1]});
        end
        acc(1'b1, IDX_STATUS, 32'h0000_0002, SIZE_DWORD);
        instr_addr_i <= $random(seed);
        pulse(5);
        acc(1'b0, IDX_INSTR_PTR, '0, SIZE_DWORD);
        chk(rdata, instr_addr_i & PTR_MASK);
        pulse(6);
        chk({31'h0, trace_trap_o}, 32'h1);
        pulse(6);
        chk({31'h0, trace_trap_o}, 32'h0);
        cfg_data_i <= 4'h1;
        pulse(7);
        tick(1);
        chk({31'h0, irq_vectored_o}, 32'h1);
        foreach (ops[j]) begin
            pulse(ops[j]);
            chk({31'h0, undef_trap_o}, 32'h1);
        end
        int_n_i <= 1'b0;
        tick(6);
        chk({31'h0, irq_take_o}, 32'h0);
        nmi_n_i <= 1'b0;
        tick(3);
        chk({31'h0, nmi_take_o}, 32'h1);
        tick(1);
        chk({31'h0, nmi_take_o}, 32'h0);
        acc(1'b1, IDX_STATUS, 32'h0000_0800, SIZE_DWORD);
        tick(4);
        chk({31'h0, irq_take_o}, 32'h1);
        acc(1'b1, IDX_STATUS, 32'h0000_0900, SIZE_DWORD);
        chk({31'h0, user_mode_o}, 32'h1);
        acc(1'b1, IDX_ITB, 32'h0, SIZE_DWORD);
        chk({31'h0, reg_denied_o}, 32'h1);
        acc(1'b1, IDX_STATUS, 32'h0, SIZE_DWORD);
        chk({31'h0, user_mode_o}, 32'h1);
        pulse(9);
        chk({31'h0, priv_trap_o}, 32'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
